/* logic/rfsw_defs.vh */
// Constants for the control-bus slave of the six-throw antenna switch.
`ifndef RFSW_DEFS_VH
`define RFSW_DEFS_VH

// Register addresses.
`define RFSW_ADDR_SELECT 5'h00
`define RFSW_ADDR_STATUS 5'h1a
`define RFSW_ADDR_GROUP 5'h1b
`define RFSW_ADDR_TRIG 5'h1c
`define RFSW_ADDR_PRODUCT 5'h1d
`define RFSW_ADDR_MFR 5'h1e
`define RFSW_ADDR_MAN_UID 5'h1f

// Status field positions.
`define RFSW_ST_SOFT_RESET 7
`define RFSW_ST_CMD_PAR 6
`define RFSW_ST_LENGTH 5
`define RFSW_ST_ADDR_PAR 4
`define RFSW_ST_DATA_PAR 3
`define RFSW_ST_RD_BAD 2
`define RFSW_ST_WR_BAD 1
`define RFSW_ST_SHARED_RD 0

// Trigger register fields: masks in bits 5 to 3, triggers in bits 2 to 0.
`define RFSW_TRIG_MASK_LSB 3
`define RFSW_TRIG_MASK_MSB 5

// Reset values.
`define RFSW_SELECT_RESET 8'h00
`define RFSW_STATUS_RESET 7'h00
`define RFSW_GROUP_RESET 4'h0
`define RFSW_UID_RESET 4'hb
`define RFSW_TRIG_RESET 5'h00
`define RFSW_BROADCAST_ID 4'h0

// Sequence bit counts, counted in sampled falling edges and driven rising edges.
`define RFSW_CMD_LAST 5'd12
`define RFSW_WR_LAST 5'd21
`define RFSW_RD_FIRST 4'd1
`define RFSW_RD_PAR 4'd9
`define RFSW_RD_PARK 4'd10
`define RFSW_RD_END 4'd11

// Select codes in bits 6 to 0 of the select register.
`define RFSW_CODE_PORT1 7'h02
`define RFSW_CODE_PORT2 7'h0a
`define RFSW_CODE_PORT3 7'h0e
`define RFSW_CODE_PORT4 7'h0b
`define RFSW_CODE_PORT5 7'h01
`define RFSW_CODE_PORT6 7'h09

`endif

/* logic/rfsw_sync.v */
// Two-flop synchroniser for one pin input.
`timescale 1ns/100ps
`default_nettype none
module rfsw_sync (
  // Clock, reset and enable.
  input wire clk,
  input wire srst,
  input wire ce,
  // Asynchronous input and its synchronised copy.
  input wire pin_in,
  output reg pin_sync
);
  reg stage_one;

  // The first stage feeds only the second, so a metastable level never reaches logic.
  always @(posedge clk) begin
    if (srst) begin
      stage_one <= 1'b0;
      pin_sync <= 1'b0;
    end else if (ce) begin
      stage_one <= pin_in;
      pin_sync <= stage_one;
    end
  end
endmodule // rfsw_sync
`default_nettype wire

/* logic/rfsw_slave.v */
// Control-bus slave that decodes command sequences and drives the antenna switch ports.
`timescale 1ns/100ps
`default_nettype none
`include "rfsw_defs.vh"
module rfsw_slave #(
  // Identification values; both are arbitrary neutral values.
  parameter [7:0] PRODUCT_CODE = 8'h5a,
  parameter [1:0] MAKER_LOW_CODE = 2'h2
) (
  // Clock, reset and enable.
  input wire clk,
  input wire srst,
  input wire ce,
  // Serial bus pins.
  input wire sclk,
  input wire sdata_in,
  output reg sdata_out,
  output reg sdata_oe,
  // Switch path controls, one high at most.
  output reg rf_port_one,
  output reg rf_port_two,
  output reg rf_port_three,
  output reg rf_port_four,
  output reg rf_port_five,
  output reg rf_port_six
);
  localparam [1:0] ST_IDLE = 2'd0;
  localparam [1:0] ST_CMD = 2'd1;
  localparam [1:0] ST_READ = 2'd2;

  wire sclk_s;
  wire sdata_s;
  reg sclk_d;
  reg sdata_d;
  reg [1:0] state;
  reg [4:0] cnt;
  reg [3:0] rcnt;
  reg [21:0] rx;
  reg [4:0] addr_q;
  reg [8:0] tx;
  reg wr_stb;
  reg [4:0] wr_addr;
  reg [7:0] wr_data;
  reg [6:0] evt;
  reg rd_clr;
  reg [7:0] switch_select;
  reg [7:0] select_shadow;
  reg [6:0] bus_error_status;
  reg [3:0] group_id;
  reg [3:0] unique_id;
  reg [4:0] power_trigger_reg;

  // Both pins come from another clock domain.
  rfsw_sync u_sync_sclk (
    .clk(clk),
    .srst(srst),
    .ce(ce),
    .pin_in(sclk),
    .pin_sync(sclk_s)
  );
  rfsw_sync u_sync_sdata (
    .clk(clk),
    .srst(srst),
    .ce(ce),
    .pin_in(sdata_in),
    .pin_sync(sdata_s)
  );

  // Edge and start detection on the synchronised pins.
  wire sclk_rise = sclk_s & ~sclk_d;
  wire sclk_fall = ~sclk_s & sclk_d;
  wire ssc = sdata_s & ~sdata_d & ~sclk_s & ~sdata_oe;
  wire [21:0] nrx = {rx[20:0], sdata_s};

  // Command frame fields as seen when its parity bit arrives.
  wire [3:0] cmd_sa = nrx[12:9];
  wire cmd_c7 = nrx[8];
  wire [1:0] cmd_kind = nrx[7:6];
  wire [4:0] cmd_addr = nrx[5:1];
  wire cmd_par_ok = ^nrx[12:0];
  wire data_par_ok = ^nrx[8:0];
  wire uid_hit = (cmd_sa == unique_id);
  wire shared_hit = (cmd_sa == `RFSW_BROADCAST_ID) || (cmd_sa == group_id);
  wire [2:0] trig_masks = power_trigger_reg[`RFSW_TRIG_MASK_MSB - 3:`RFSW_TRIG_MASK_LSB - 3];

  // Addresses that hold a register.
  function implemented;
    input [4:0] a;
    begin
      implemented = (a == `RFSW_ADDR_SELECT) || (a >= `RFSW_ADDR_STATUS);
    end
  endfunction

  // Read data; the soft-reset bit and trigger bits always read as zero.
  function [7:0] read_byte;
    input [4:0] a;
    begin
      if (a == `RFSW_ADDR_SELECT) begin
        read_byte = switch_select;
      end else if (a == `RFSW_ADDR_STATUS) begin
        read_byte = {1'b0, bus_error_status};
      end else if (a == `RFSW_ADDR_GROUP) begin
        read_byte = {4'h0, group_id};
      end else if (a == `RFSW_ADDR_TRIG) begin
        read_byte = {power_trigger_reg, 3'h0};
      end else if (a == `RFSW_ADDR_PRODUCT) begin
        read_byte = PRODUCT_CODE;
      end else if (a == `RFSW_ADDR_MFR) begin
        read_byte = {PRODUCT_CODE[3:0], PRODUCT_CODE[7:4]};
      end else begin
        read_byte = {2'h0, MAKER_LOW_CODE, unique_id};
      end
    end
  endfunction

  wire [7:0] rd_byte = read_byte(cmd_addr);

  // Sequence decoder; a start inside a command or write frame restarts it and flags a length error.
  always @(posedge clk) begin
    if (srst) begin
      sclk_d <= 1'b0;
      sdata_d <= 1'b0;
      state <= ST_IDLE;
      cnt <= 5'd0;
      rcnt <= 4'd0;
      rx <= 22'h000000;
      addr_q <= 5'h00;
      tx <= 9'h000;
      wr_stb <= 1'b0;
      wr_addr <= 5'h00;
      wr_data <= 8'h00;
      evt <= 7'h00;
      rd_clr <= 1'b0;
      sdata_out <= 1'b0;
      sdata_oe <= 1'b0;
    end else if (ce) begin
      sclk_d <= sclk_s;
      sdata_d <= sdata_s;
      wr_stb <= 1'b0;
      evt <= 7'h00;
      rd_clr <= 1'b0;
      if (ssc) begin
        if (state == ST_CMD) begin
          evt[`RFSW_ST_LENGTH] <= 1'b1;
        end
        state <= ST_CMD;
        cnt <= 5'd0;
      end else begin
        case (state)
          ST_CMD: begin
            if (sclk_fall) begin
              rx <= nrx;
              cnt <= cnt + 5'd1;
              if (cnt == `RFSW_CMD_LAST) begin
                state <= ST_IDLE;
                if (!cmd_par_ok) begin
                  evt[`RFSW_ST_CMD_PAR] <= 1'b1;
                  evt[`RFSW_ST_ADDR_PAR] <= ~cmd_c7;
                end else if (!(uid_hit || shared_hit)) begin
                  state <= ST_IDLE;
                end else if (cmd_c7) begin
                  wr_stb <= 1'b1;
                  wr_addr <= `RFSW_ADDR_SELECT;
                  wr_data <= {1'b0, nrx[7:1]};
                end else if (cmd_kind == 2'b10) begin
                  addr_q <= cmd_addr;
                  state <= ST_CMD;
                end else if (cmd_kind == 2'b11) begin
                  if (!uid_hit) begin
                    evt[`RFSW_ST_SHARED_RD] <= 1'b1;
                  end else if (!implemented(cmd_addr)) begin
                    evt[`RFSW_ST_RD_BAD] <= 1'b1;
                  end else begin
                    tx <= {rd_byte, ~^rd_byte};
                    rd_clr <= (cmd_addr == `RFSW_ADDR_STATUS);
                    rcnt <= 4'd0;
                    state <= ST_READ;
                  end
                end
              end else if (cnt == `RFSW_WR_LAST) begin
                state <= ST_IDLE;
                if (!data_par_ok) begin
                  evt[`RFSW_ST_DATA_PAR] <= 1'b1;
                end else if (!implemented(addr_q)) begin
                  evt[`RFSW_ST_WR_BAD] <= 1'b1;
                end else begin
                  wr_stb <= 1'b1;
                  wr_addr <= addr_q;
                  wr_data <= nrx[8:1];
                end
              end
            end
          end
          ST_READ: begin
            // The first rising edge is the master's park cycle, then nine bits, then our park.
            if (sclk_rise) begin
              rcnt <= rcnt + 4'd1;
              if (rcnt >= `RFSW_RD_FIRST && rcnt <= `RFSW_RD_PAR) begin
                sdata_oe <= 1'b1;
                sdata_out <= tx[8];
                tx <= {tx[7:0], 1'b0};
              end else if (rcnt == `RFSW_RD_PARK) begin
                sdata_out <= 1'b0;
              end
            end else if (sclk_fall && rcnt == `RFSW_RD_END) begin
              sdata_oe <= 1'b0;
              state <= ST_IDLE;
            end
          end
          default: begin
            state <= ST_IDLE;
          end
        endcase
      end
    end
  end

  // Register file; a fired trigger and a direct write both land in the same cycle as the write.
  wire soft_reset = wr_stb && (wr_addr == `RFSW_ADDR_STATUS) && wr_data[`RFSW_ST_SOFT_RESET];
  wire all_masked = &trig_masks;
  wire trig_fire = wr_stb && (wr_addr == `RFSW_ADDR_TRIG) &&
    |(wr_data[2:0] & ~wr_data[`RFSW_TRIG_MASK_MSB:`RFSW_TRIG_MASK_LSB]);
  always @(posedge clk) begin
    if (srst) begin
      switch_select <= `RFSW_SELECT_RESET;
      select_shadow <= `RFSW_SELECT_RESET;
      bus_error_status <= `RFSW_STATUS_RESET;
      group_id <= `RFSW_GROUP_RESET;
      unique_id <= `RFSW_UID_RESET;
      power_trigger_reg <= `RFSW_TRIG_RESET;
    end else if (ce) begin
      if (soft_reset) begin
        switch_select <= `RFSW_SELECT_RESET;
        select_shadow <= `RFSW_SELECT_RESET;
        bus_error_status <= `RFSW_STATUS_RESET;
      end else begin
        // A flag raised in the cycle of a clearing read survives it.
        if (rd_clr) begin
          bus_error_status <= evt;
        end else begin
          bus_error_status <= bus_error_status | evt;
        end
        if (wr_stb && wr_addr == `RFSW_ADDR_SELECT) begin
          if (all_masked) begin
            switch_select <= wr_data;
          end else begin
            select_shadow <= wr_data;
          end
        end else if (trig_fire) begin
          switch_select <= select_shadow;
        end
      end
      if (wr_stb && wr_addr == `RFSW_ADDR_GROUP) begin
        group_id <= wr_data[3:0];
      end
      if (wr_stb && wr_addr == `RFSW_ADDR_TRIG) begin
        power_trigger_reg <= wr_data[7:3];
      end
      if (wr_stb && wr_addr == `RFSW_ADDR_MAN_UID) begin
        unique_id <= wr_data[3:0];
      end
    end
  end

  // Port decode ignores bit 7; anything unlisted isolates all paths.
  always @(posedge clk) begin
    if (srst) begin
      {rf_port_one, rf_port_two, rf_port_three, rf_port_four, rf_port_five, rf_port_six} <= 6'h00;
    end else if (ce) begin
      case (switch_select[6:0])
        `RFSW_CODE_PORT1: {rf_port_one, rf_port_two, rf_port_three, rf_port_four, rf_port_five, rf_port_six} <= 6'h20;
        `RFSW_CODE_PORT2: {rf_port_one, rf_port_two, rf_port_three, rf_port_four, rf_port_five, rf_port_six} <= 6'h10;
        `RFSW_CODE_PORT3: {rf_port_one, rf_port_two, rf_port_three, rf_port_four, rf_port_five, rf_port_six} <= 6'h08;
        `RFSW_CODE_PORT4: {rf_port_one, rf_port_two, rf_port_three, rf_port_four, rf_port_five, rf_port_six} <= 6'h04;
        `RFSW_CODE_PORT5: {rf_port_one, rf_port_two, rf_port_three, rf_port_four, rf_port_five, rf_port_six} <= 6'h02;
        `RFSW_CODE_PORT6: {rf_port_one, rf_port_two, rf_port_three, rf_port_four, rf_port_five, rf_port_six} <= 6'h01;
        default: {rf_port_one, rf_port_two, rf_port_three, rf_port_four, rf_port_five, rf_port_six} <= 6'h00;
      endcase
    end
  end
endmodule // rfsw_slave
`default_nettype wire

/* verif/rfsw_slave_asserts.sv */
// Pin-level assertions for the switch control slave.
`timescale 1ns/100ps
`default_nettype none
module rfsw_slave_chk (
  // Clock and reset.
  input wire logic clk,
  input wire logic srst,
  input wire logic ce,
  // Bus pins.
  input wire logic sclk,
  input wire logic sdata_in,
  input wire logic sdata_out,
  input wire logic sdata_oe,
  // Path enables.
  input wire logic rf_port_one,
  input wire logic rf_port_two,
  input wire logic rf_port_three,
  input wire logic rf_port_four,
  input wire logic rf_port_five,
  input wire logic rf_port_six
);
  wire [5:0] ports = {rf_port_six, rf_port_five, rf_port_four, rf_port_three, rf_port_two, rf_port_one};
  logic [7:0] oe_len;
  // Counts the drive window; a read holds the line for nine and a half bit times.
  always_ff @(posedge clk) begin
    if (srst || !sdata_oe) oe_len <= 8'h00;
    else oe_len <= oe_len + 8'h01;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  sequence s_port_move;
    $changed(ports);
  endsequence
  sequence s_quiet;
    !sdata_oe [*8];
  endsequence
  a_port_onehot: assert property ($onehot0(ports)) else $error("two paths on");
  a_reset_isolate: assert property ($fell(srst) |-> ports == 6'h00 && !sdata_oe) else $error("not idle");
  a_quiet_start: assert property ($fell(srst) |-> s_quiet) else $error("early drive");
  a_drive_hold: assert property (sdata_oe && $changed(sdata_out) |=> $stable(sdata_out) [*8])
    else $error("read bit too short");
  a_park_low: assert property ($fell(sdata_oe) |-> !$past(sdata_out)) else $error("park not low");
  a_drive_len: assert property ($fell(sdata_oe) |-> oe_len >= 8'd110 && oe_len <= 8'd118)
    else $error("drive window length");
  a_port_steady: assert property (s_port_move |-> !sdata_oe) else $error("path moved in read");
  a_port_settle: assert property (s_port_move |=> $stable(ports) [*8]) else $error("path glitch");
endmodule // rfsw_slave_chk
`default_nettype wire

/* verif/rfsw_bus_master.sv */
// Behavioural bus master that clocks sequences into the slave.
`timescale 1ns/100ps
`default_nettype none
module rfsw_bus_master (
  // Clock.
  input wire logic clk,
  // Slave drive of the data line.
  input wire logic sdata_out,
  input wire logic sdata_oe,
  // Bus pins.
  output logic sclk,
  output wire logic sdata
);
  logic m_en;
  logic m_d;
  // A released line floats high, the inverse of the park level, so a missing drive never reads as zero.
  // It stays still on purpose: a line that toggles under a low clock would look like a new start.
  assign sdata = sdata_oe ? sdata_out : (m_en ? m_d : 1'b1);
  // Idle bus: clock low, data held low.
  initial begin
    sclk = 1'b0;
    m_en = 1'b1;
    m_d = 1'b0;
  end
  task half;
    repeat (6) @(negedge clk);
  endtask
  task ssc;
    m_d = 1'b1;
    half;
    m_d = 1'b0;
    half;
  endtask
  task bit1(input logic b);
    sclk = 1'b1;
    m_d = b;
    half;
    sclk = 1'b0;
    half;
  endtask
  task cmd(input logic [11:0] c, input logic bad);
    for (int i = 11; i >= 0; i--) bit1(c[i]);
    bit1(~^c ^ bad);
  endtask
  task dat(input logic [7:0] d, input logic bad);
    for (int i = 7; i >= 0; i--) bit1(d[i]);
    bit1(~^d ^ bad);
  endtask
  task park;
    bit1(1'b0);
    repeat (12) @(negedge clk);
  endtask
  task get(output logic [7:0] d, output logic p);
    logic [8:0] v;
    bit1(1'b0);
    m_en = 1'b0;
    for (int i = 0; i < 9; i++) begin
      sclk = 1'b1;
      half;
      v = {v[7:0], sdata};
      sclk = 1'b0;
      half;
    end
    // Take the line back while the clock is high, before the slave lets go after its park bit.
    sclk = 1'b1;
    half;
    m_en = 1'b1;
    sclk = 1'b0;
    half;
    repeat (12) @(negedge clk);
    d = v[8:1];
    p = v[0];
  endtask
endmodule // rfsw_bus_master
`default_nettype wire

/* verif/testbench.sv */
// Self-checking bench for the switch control slave.
`timescale 1ns/100ps
`default_nettype none
module testbench;
  logic clk;
  logic srst;
  logic ce;
  wire sclk;
  wire sdata;
  wire sdata_out;
  wire sdata_oe;
  wire [5:0] ports;
  int n_errors;
  int n_checks;
  logic [3:0] uid;
  logic [6:0] codes [8] = '{7'h02, 7'h0a, 7'h0e, 7'h0b, 7'h01, 7'h09, 7'h7f, 7'h00};
  logic [7:0] pexp [8] = '{8'h01, 8'h02, 8'h04, 8'h08, 8'h10, 8'h20, 8'h00, 8'h00};
  rfsw_slave #(.PRODUCT_CODE(8'h3c), .MAKER_LOW_CODE(2'h1)) dut (.clk(clk), .srst(srst), .ce(ce),
    .sclk(sclk), .sdata_in(sdata), .sdata_out(sdata_out), .sdata_oe(sdata_oe),
    .rf_port_one(ports[0]), .rf_port_two(ports[1]), .rf_port_three(ports[2]),
    .rf_port_four(ports[3]), .rf_port_five(ports[4]), .rf_port_six(ports[5]));
  rfsw_bus_master m (.clk(clk), .sdata_out(sdata_out), .sdata_oe(sdata_oe), .sclk(sclk), .sdata(sdata));
  task test_done;
    $display("checks %0d mismatches %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task cmp(input logic [7:0] got, input logic [7:0] exp, input string what);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask
  task w0(input logic [3:0] sa, input logic [6:0] c, input logic bad);
    m.ssc;
    m.cmd({sa, 1'b1, c}, bad);
    m.park;
  endtask
  task wr(input logic [3:0] sa, input logic [4:0] a, input logic [7:0] d, input logic bc, input logic bd);
    m.ssc;
    m.cmd({sa, 3'b010, a}, bc);
    m.dat(d, bd);
    m.park;
  endtask
  task rd(input logic [3:0] sa, input logic [4:0] a, input logic [7:0] exp, input logic chk);
    logic [7:0] d;
    logic p;
    m.ssc;
    m.cmd({sa, 3'b011, a}, 1'b0);
    m.get(d, p);
    if (chk) cmp(d, exp, "read data");
    if (chk) cmp({7'h00, p}, {7'h00, ~^d}, "read parity");
  endtask
  // Free-running system clock at 250 MHz.
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // Cuts a hang short well past the expected run length.
  initial begin
    #300000;
    n_errors++;
    $display("wrong value at %0t: watchdog expired", $time);
    test_done;
  end
  // Main sequence; the status register clears on read, so each error case reads it alone.
  initial begin
    srst = 1'b1;
    ce = 1'b1;
    n_errors = 0;
    n_checks = 0;
    uid = 4'hb;
    repeat (16) @(negedge clk);
    srst = 1'b0;
    repeat (4) @(negedge clk);
    cmp({2'b00, ports}, 8'h00, "reset paths");
    rd(uid, 5'h1a, 8'h00, 1'b1);
    rd(uid, 5'h1b, 8'h00, 1'b1);
    wr(uid, 5'h1c, 8'h38, 1'b0, 1'b0);
    for (int i = 0; i < 8; i++) begin
      w0(uid, codes[i], 1'b0);
      cmp({2'b00, ports}, pexp[i], "path decode");
    end
    wr(uid, 5'h00, 8'h0e, 1'b0, 1'b0);
    rd(uid, 5'h00, 8'h0e, 1'b1);
    wr(uid, 5'h1c, 8'h00, 1'b0, 1'b0);
    w0(uid, 7'h02, 1'b0);
    cmp({2'b00, ports}, 8'h04, "shadow held");
    wr(uid, 5'h1c, 8'h01, 1'b0, 1'b0);
    cmp({2'b00, ports}, 8'h01, "trigger moved");
    $display("test decode done");
    w0(uid, 7'h0a, 1'b1);
    cmp({2'b00, ports}, 8'h01, "discarded");
    rd(uid, 5'h1a, 8'h40, 1'b1);
    wr(uid, 5'h1b, 8'h05, 1'b1, 1'b0);
    rd(uid, 5'h1a, 8'h50, 1'b1);
    wr(uid, 5'h1b, 8'h05, 1'b0, 1'b1);
    rd(uid, 5'h1a, 8'h08, 1'b1);
    rd(uid, 5'h05, 8'h00, 1'b0);
    rd(uid, 5'h1a, 8'h04, 1'b1);
    wr(uid, 5'h05, 8'h11, 1'b0, 1'b0);
    rd(uid, 5'h1a, 8'h02, 1'b1);
    rd(4'h0, 5'h00, 8'h00, 1'b0);
    rd(uid, 5'h1a, 8'h01, 1'b1);
    $display("test status done");
    wr(uid, 5'h1c, 8'h38, 1'b0, 1'b0);
    w0(4'h3, 7'h09, 1'b0);
    cmp({2'b00, ports}, 8'h01, "foreign id");
    wr(uid, 5'h1f, 8'h03, 1'b0, 1'b0);
    uid = 4'h3;
    rd(uid, 5'h1f, 8'h13, 1'b1);
    w0(uid, 7'h09, 1'b0);
    cmp({2'b00, ports}, 8'h20, "new id");
    wr(uid, 5'h1b, 8'h05, 1'b0, 1'b0);
    wr(uid, 5'h1a, 8'h80, 1'b0, 1'b0);
    cmp({2'b00, ports}, 8'h00, "soft reset");
    rd(uid, 5'h00, 8'h00, 1'b1);
    rd(uid, 5'h1b, 8'h05, 1'b1);
    rd(uid, 5'h1c, 8'h38, 1'b1);
    rd(uid, 5'h1d, 8'h3c, 1'b1);
    rd(4'h5, 5'h00, 8'h00, 1'b0);
    rd(uid, 5'h1a, 8'h01, 1'b1);
    $display("test identity done");
    test_done;
  end
endmodule // testbench
bind rfsw_slave rfsw_slave_chk chk (.clk(clk), .srst(srst), .ce(ce), .sclk(sclk), .sdata_in(sdata_in),
  .sdata_out(sdata_out), .sdata_oe(sdata_oe), .rf_port_one(rf_port_one), .rf_port_two(rf_port_two),
  .rf_port_three(rf_port_three), .rf_port_four(rf_port_four), .rf_port_five(rf_port_five),
  .rf_port_six(rf_port_six));
`default_nettype wire
